/* File: logic/slp_strap_misc.sv */
// file: strap latching, serial rom select, gpio, interrupt and wake pins
// How it works
// - rom select pin follows the three-wire select in kind 0, else low.
// - straps are caught when power-on or pin reset releases; used as defaults.
// - latched low size strap is bit 0 of the rom size selection.
// - per port, crossover off if its strap latched low, on if high.
// - the rom loader may replace latched strap values after reset.
// - each upper gpio is push-pull, open-drain or schmitt input.
// - gpio input buffer only enabled while configured as input.
// - interrupt polarity, source and output type are programmable.
// - pin reset low resets the block; internal power-on reset also.
// - wake output asserts on wake events when enabled; polarity, type set.
// - rom kind strap: 0 three-wire, 1 two-wire.
// - high size strap is the upper size bit, ignored in two-wire mode.
`timescale 1ns/10ps
`default_nettype none

module slp_strap_misc #(
  parameter int GPIO_N    = slp_pkg::GPIO_N,
  parameter int POR_WAIT  = 16
) (
  input  wire logic                            clk,
  input  wire logic                            rst_b,
  input  wire logic                            clk_en,
  input  wire logic                            power_on_reset_low_in,
  input  wire logic                            system_reset_low_in,
  input  wire logic [slp_pkg::STRAP_W-1:0]     strap_pins_in,
  input  wire logic                            loader_override_stb,
  input  wire logic [slp_pkg::STRAP_W-1:0]     loader_override_mask,
  input  wire logic [slp_pkg::STRAP_W-1:0]     loader_override_val,
  input  wire logic                            rom_select_req,
  input  wire logic [2*GPIO_N-1:0]             gpio_mode_cfg,
  input  wire logic [GPIO_N-1:0]               gpio_out_data,
  input  wire logic [GPIO_N-1:0]               gpio_pin_in,
  input  wire logic [1:0]                      irq_source_sel,
  input  wire logic [3:0]                      irq_sources,
  input  wire logic                            irq_cfg_enable,
  input  wire logic                            irq_cfg_act_high,
  input  wire logic                            irq_cfg_push_pull,
  input  wire logic                            wake_event_enable_bit,
  input  wire logic                            wake_cfg_act_high,
  input  wire logic                            wake_cfg_push_pull,
  input  wire logic                            wake_detect,
  output logic                                 chip_reset_active,
  output logic                                 serial_rom_select_out,
  output logic                                 rom_two_wire,
  output logic [1:0]                           rom_size_sel,
  output logic                                 port1_crossover_en,
  output logic                                 port2_crossover_en,
  output logic [GPIO_N-1:0]                    gpio_pin_out,
  output logic [GPIO_N-1:0]                    gpio_pin_oe,
  output logic [GPIO_N-1:0]                    gpio_in_buf_en,
  output logic [GPIO_N-1:0]                    gpio_data_in,
  output logic                                 irq_pin_out,
  output logic                                 irq_pin_oe,
  output logic                                 wake_event_out,
  output logic                                 wake_event_oe
);

  // ===========================================================================
  // elaboration checks
  if (GPIO_N < 1 || GPIO_N > 16) begin : g_chk_gpio
    $error("GPIO_N out of range");
  end
  if (POR_WAIT < 2 || POR_WAIT > 255) begin : g_chk_por
    $error("POR_WAIT out of range");
  end

  // ===========================================================================
  // state record
  typedef struct packed {
    slp_pkg::slp_state_t           st;
    logic [7:0]                    por_cnt;
    logic [2:0]                    prst_sync;
    logic                          prst_q;
    logic [2:0]                    system_reset_low_in_sync;
    logic                          system_reset_low_in_q;
    logic [slp_pkg::STRAP_W-1:0]   strap;
    logic [GPIO_N-1:0]             gin_s1;
    logic [GPIO_N-1:0]             gin_s2;
    logic [GPIO_N-1:0]             gin_s3;
    logic [GPIO_N-1:0]             gin_q;
    logic                          rom_sel;
    logic                          irq_act;
    logic                          wake_act;
  } slp_core_t;

  slp_core_t core_reg;
  slp_core_t core_next;

  // pin mode decode, used by every gpio lane
  function automatic slp_pkg::slp_pin_mode_t pin_mode(
    input logic [2*GPIO_N-1:0] cfg,
    input int                  idx
  );
    logic [1:0] code;
    code = cfg[2*idx +: 2];
    case (code)
      2'b01:   pin_mode = slp_pkg::SLP_PIN_PUSH_PULL;
      2'b10:   pin_mode = slp_pkg::SLP_PIN_OPEN_DRN;
      default: pin_mode = slp_pkg::SLP_PIN_INPUT;
    endcase
  endfunction

  logic in_reset;
  logic release_now;

  // chip reset held while either synchronised reset source reads low
  assign in_reset    = ~core_reg.prst_q | ~core_reg.system_reset_low_in_q;
  assign release_now = (core_reg.st == slp_pkg::SLP_ST_LATCH) &&
                       (core_reg.por_cnt == 8'h00);

  // ===========================================================================
  // next state
  always_comb begin
    core_next = core_reg;
    // three-flop synchronisers; change accepted when stages two and three agree
    core_next.prst_sync = {core_reg.prst_sync[1:0], power_on_reset_low_in};
    core_next.system_reset_low_in_sync = {core_reg.system_reset_low_in_sync[1:0], system_reset_low_in};
    core_next.gin_s1    = gpio_pin_in;
    core_next.gin_s2    = core_reg.gin_s1;
    core_next.gin_s3    = core_reg.gin_s2;
    if (core_reg.prst_sync[1] == core_reg.prst_sync[2]) begin
      core_next.prst_q = core_reg.prst_sync[2];
    end
    if (core_reg.system_reset_low_in_sync[1] == core_reg.system_reset_low_in_sync[2]) begin
      core_next.system_reset_low_in_q = core_reg.system_reset_low_in_sync[2];
    end
    for (int i = 0; i < GPIO_N; i++) begin
      if (core_reg.gin_s2[i] == core_reg.gin_s3[i]) begin
        core_next.gin_q[i] = core_reg.gin_s3[i];
      end
    end

    // sequencer: wait out a settle period, then catch the straps once
    case (core_reg.st)
      slp_pkg::SLP_ST_RESET: begin
        core_next.por_cnt = 8'(POR_WAIT - 1);
        if (!in_reset) begin
          core_next.st = slp_pkg::SLP_ST_LATCH;
        end
      end
      slp_pkg::SLP_ST_LATCH: begin
        core_next.por_cnt = core_reg.por_cnt - 8'h01;
        if (in_reset) begin
          core_next.st = slp_pkg::SLP_ST_RESET;
        end else if (release_now) begin
          core_next.strap = strap_pins_in;
          core_next.st    = slp_pkg::SLP_ST_RUN;
        end
      end
      slp_pkg::SLP_ST_RUN: begin
        if (in_reset) begin
          core_next.st = slp_pkg::SLP_ST_RESET;
        end else if (loader_override_stb) begin
          // only the loader may alter latched values after the catch
          core_next.strap = (core_reg.strap & ~loader_override_mask) |
                    (loader_override_val & loader_override_mask);
        end
      end
      default: core_next.st = slp_pkg::SLP_ST_RESET;
    endcase

    // decided from the next state so requests drop on the reset edge itself
    if (core_next.st != slp_pkg::SLP_ST_RUN) begin
      core_next.rom_sel  = 1'b0;
      core_next.irq_act  = 1'b0;
      core_next.wake_act = 1'b0;
    end else begin
      core_next.rom_sel  = rom_select_req &
                           ~core_next.strap[slp_pkg::STRAP_ROM_KIND];
      core_next.irq_act  = irq_sources[irq_source_sel];
      core_next.wake_act = wake_detect;
    end
  end

  // ===========================================================================
  // state register; clock enable freezes everything
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      core_reg           <= '0;
      core_reg.strap     <= slp_pkg::STRAP_RESET;
      core_reg.st        <= slp_pkg::SLP_ST_RESET;
    end else if (clk_en) begin
      core_reg <= core_next;
    end
  end

  // ===========================================================================
  // strap decode
  assign chip_reset_active     = core_reg.st != slp_pkg::SLP_ST_RUN;
  assign rom_two_wire          = core_reg.strap[slp_pkg::STRAP_ROM_KIND];
  assign rom_size_sel[0]       = core_reg.strap[slp_pkg::STRAP_SIZE_LO];
  // high bit means nothing to a two-wire part, so report it as zero there
  assign rom_size_sel[1]       = core_reg.strap[slp_pkg::STRAP_SIZE_HI] &
                                 ~core_reg.strap[slp_pkg::STRAP_ROM_KIND];
  assign port1_crossover_en    = core_reg.strap[slp_pkg::STRAP_XOVER1];
  assign port2_crossover_en    = core_reg.strap[slp_pkg::STRAP_XOVER2];
  assign serial_rom_select_out = core_reg.rom_sel;

  // ===========================================================================
  // gpio lanes
  always_comb begin
    for (int i = 0; i < GPIO_N; i++) begin
      case (pin_mode(gpio_mode_cfg, i))
        slp_pkg::SLP_PIN_PUSH_PULL: begin
          gpio_pin_out[i]   = gpio_out_data[i];
          gpio_pin_oe[i]    = 1'b1;
          gpio_in_buf_en[i] = 1'b0;
        end
        slp_pkg::SLP_PIN_OPEN_DRN: begin
          gpio_pin_out[i]   = 1'b0;
          gpio_pin_oe[i]    = ~gpio_out_data[i];
          gpio_in_buf_en[i] = 1'b0;
        end
        default: begin
          gpio_pin_out[i]   = 1'b0;
          gpio_pin_oe[i]    = 1'b0;
          gpio_in_buf_en[i] = 1'b1;
        end
      endcase
      // a disabled buffer reads zero rather than a floating pin
      gpio_data_in[i] = core_reg.gin_q[i] & gpio_in_buf_en[i];
    end
  end

  // ===========================================================================
  // interrupt and wake pins
  slp_pkg::slp_outcfg_t irq_cfg;
  slp_pkg::slp_outcfg_t wake_cfg;
  slp_pkg::slp_drive_t  irq_drv;
  slp_pkg::slp_drive_t  wake_drv;

  assign irq_cfg  = '{enable: irq_cfg_enable, act_high: irq_cfg_act_high,
                      push_pull: irq_cfg_push_pull};
  assign wake_cfg = '{enable: wake_event_enable_bit,
                      act_high: wake_cfg_act_high,
                      push_pull: wake_cfg_push_pull};

  slp_out_pin u_irq_pin (
    .active (core_reg.irq_act),
    .cfg    (irq_cfg),
    .pin    (irq_drv)
  );

  slp_out_pin u_wake_pin (
    .active (core_reg.wake_act),
    .cfg    (wake_cfg),
    .pin    (wake_drv)
  );

  assign irq_pin_out    = irq_drv.o;
  assign irq_pin_oe     = irq_drv.oe;
  assign wake_event_out = wake_drv.o;
  assign wake_event_oe  = wake_drv.oe;

  // ===========================================================================
  // assertions
  sequence s_latching;
    core_reg.st == slp_pkg::SLP_ST_LATCH && core_reg.por_cnt == 8'h00 &&
    !in_reset && clk_en;
  endsequence

  a_strap_catch_value: assert property (@(posedge clk) disable iff (!rst_b)
    s_latching |=> core_reg.strap == $past(strap_pins_in))
    else $error("straps not caught at release");

  a_strap_hold_run: assert property (@(posedge clk) disable iff (!rst_b)
    (core_reg.st == slp_pkg::SLP_ST_RUN && !loader_override_stb && clk_en)
    |=> $stable(core_reg.strap))
    else $error("straps changed without loader");

  a_loader_apply: assert property (@(posedge clk) disable iff (!rst_b)
    (core_reg.st == slp_pkg::SLP_ST_RUN && !in_reset && loader_override_stb &&
     clk_en && loader_override_mask[0])
    |=> core_reg.strap[0] == $past(loader_override_val[0]))
    else $error("loader override lost");

  a_rom_sel_low: assert property (@(posedge clk) disable iff (!rst_b)
    rom_two_wire |-> !serial_rom_select_out)
    else $error("rom select driven in two-wire mode");

  a_size_hi_mask: assert property (@(posedge clk) disable iff (!rst_b)
    rom_two_wire |-> !rom_size_sel[1])
    else $error("size high bit used in two-wire mode");

  a_size_lo_map: assert property (@(posedge clk) disable iff (!rst_b)
    rom_size_sel[0] == core_reg.strap[slp_pkg::STRAP_SIZE_LO])
    else $error("size low bit mismatch");

  a_xover_map: assert property (@(posedge clk) disable iff (!rst_b)
    port1_crossover_en == core_reg.strap[slp_pkg::STRAP_XOVER1] &&
    port2_crossover_en == core_reg.strap[slp_pkg::STRAP_XOVER2])
    else $error("crossover enable mismatch");

  a_gpio_inbuf: assert property (@(posedge clk) disable iff (!rst_b)
    gpio_in_buf_en[0] |-> !gpio_pin_oe[0])
    else $error("input buffer on while driving");

  a_gpio_pushpull: assert property (@(posedge clk) disable iff (!rst_b)
    gpio_mode_cfg[1:0] == 2'b01 |-> gpio_pin_oe[0] &&
    gpio_pin_out[0] == gpio_out_data[0])
    else $error("push-pull lane wrong");

  a_reset_reacts: assert property (@(posedge clk) disable iff (!rst_b)
    (clk_en && !system_reset_low_in)[*5] |=> chip_reset_active)
    else $error("pin reset not honoured");

  a_irq_quiet_reset: assert property (@(posedge clk) disable iff (!rst_b)
    chip_reset_active |-> !core_reg.irq_act && !core_reg.wake_act)
    else $error("request active during reset");

  a_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
    (irq_cfg_push_pull && !irq_cfg_enable) |->
    irq_pin_out == ~irq_cfg_act_high)
    else $error("irq not at inactive level");

  a_wake_assert: assert property (@(posedge clk) disable iff (!rst_b)
    (wake_event_enable_bit && wake_cfg_push_pull && core_reg.wake_act) |->
    wake_event_out == wake_cfg_act_high)
    else $error("wake not asserted");

endmodule

`default_nettype wire

/* File: logic/slp_pkg.sv */
// package: strap latch and misc pin constants and carrier types
package slp_pkg;

  // ===========================================================================
  // strap field positions in the latched strap word
  localparam int STRAP_W          = 5;
  localparam int STRAP_ROM_KIND   = 0;
  localparam int STRAP_SIZE_LO    = 1;
  localparam int STRAP_SIZE_HI    = 2;
  localparam int STRAP_XOVER1     = 3;
  localparam int STRAP_XOVER2     = 4;
  // pull-up straps default high, rom kind and size default low
  localparam logic [4:0] STRAP_RESET = 5'h18;

  // ===========================================================================
  // gpio pin configuration codes
  localparam int GPIO_N = 4;
  typedef enum logic [1:0] {
    SLP_PIN_INPUT     = 2'b00,
    SLP_PIN_PUSH_PULL = 2'b01,
    SLP_PIN_OPEN_DRN  = 2'b10
  } slp_pin_mode_t;

  // ===========================================================================
  // latch sequencer states
  typedef enum logic [1:0] {
    SLP_ST_RESET = 2'b00,
    SLP_ST_LATCH = 2'b01,
    SLP_ST_RUN   = 2'b10
  } slp_state_t;

  // interrupt / wake output control group
  typedef struct packed {
    logic enable;     // source enable
    logic act_high;   // polarity
    logic push_pull;  // 1 push-pull, 0 open drain
  } slp_outcfg_t;

  // tri-state pin result
  typedef struct packed {
    logic o;
    logic oe;
  } slp_drive_t;

endpackage

/* File: logic/slp_out_pin.sv */
// file: programmable polarity / type request output pin
`timescale 1ns/10ps
`default_nettype none

module slp_out_pin (
  input  wire logic                 active,
  input  wire slp_pkg::slp_outcfg_t cfg,
  output slp_pkg::slp_drive_t       pin
);

  logic asserted;

  // inactive level follows programmed polarity until a source is live
  assign asserted = cfg.enable & active;

  // open drain drives only the low level, floats the high level
  always_comb begin
    if (cfg.push_pull) begin
      pin.o  = asserted ~^ cfg.act_high;
      pin.oe = 1'b1;
    end else begin
      pin.o  = 1'b0;
      pin.oe = asserted ? ~cfg.act_high : cfg.act_high;
    end
  end

endmodule

`default_nettype wire

/* File: verification/slp_far_side.sv */
// far side model: reset source, strap resistors and pulled-up pin wires
`timescale 1ns/10ps
`default_nettype none

module slp_far_side (
  input  wire logic       rst_req,
  input  wire logic       strap_drv,
  input  wire logic [4:0] strap_val,
  input  wire logic [3:0] gpio_o,
  input  wire logic [3:0] gpio_oe,
  input  wire logic [3:0] gpio_ext_low,
  input  wire logic       irq_o,
  input  wire logic       irq_oe,
  input  wire logic       wake_o,
  input  wire logic       wake_oe,
  output logic            sys_rst_b,
  output logic [4:0]      strap_pins,
  output logic [3:0]      gpio_wire,
  output logic            irq_wire,
  output logic            wake_wire
);
  logic [4:0] last_strap;

  // ===========================================================================
  // reset source: pulls the pin low on request, pull-up otherwise
  assign sys_rst_b = !rst_req;

  // released straps: crossover pins have pull-ups, the others show the
  // inverse of the last value so a late sample cannot pass by luck
  always @* begin
    if (strap_drv) begin
      last_strap = strap_val;
    end
  end
  assign strap_pins = strap_drv ? strap_val : {2'b11, ~last_strap[2:0]};

  // pulled-up wires; an external part may also pull a gpio low
  assign gpio_wire = ~(gpio_oe & ~gpio_o) & ~gpio_ext_low;
  assign irq_wire  = irq_oe ? irq_o : 1'b1;
  assign wake_wire = wake_oe ? wake_o : 1'b1;
endmodule
`default_nettype wire

/* File: verification/slp_strap_misc_tb.sv */
// testbench: strap latch, rom select, gpio, interrupt and wake pins
`timescale 1ns/10ps
`default_nettype none

module slp_strap_misc_tb;
  logic       clk, rst_b, clk_en, por_b, rst_req, strap_drv;
  logic [4:0] strap_val, ov_mask, ov_val, straps;
  logic       ov_stb, rom_req, irq_en, irq_hi, irq_pp;
  logic [7:0] gpio_mode;
  logic [3:0] gpio_dat, ext_low, irq_src, g_out, g_oe, g_buf, g_din;
  logic [3:0] gpio_wire;
  logic [1:0] irq_sel, size_sel;
  logic       wk_en, wk_hi, wk_pp, wk_det, sys_rst_b, chip_rst, rom_sel;
  logic       two_wire, x1, x2, irq_o, irq_oe, wk_o, wk_oe;
  logic       irq_wire, wake_wire;
  int         err_total, checks;

  slp_strap_misc #(.POR_WAIT(2)) dut (
    .clk(clk), .rst_b(rst_b), .clk_en(clk_en),
    .power_on_reset_low_in(por_b), .system_reset_low_in(sys_rst_b),
    .strap_pins_in(straps), .loader_override_stb(ov_stb),
    .loader_override_mask(ov_mask), .loader_override_val(ov_val),
    .rom_select_req(rom_req), .gpio_mode_cfg(gpio_mode),
    .gpio_out_data(gpio_dat), .gpio_pin_in(gpio_wire),
    .irq_source_sel(irq_sel), .irq_sources(irq_src),
    .irq_cfg_enable(irq_en), .irq_cfg_act_high(irq_hi),
    .irq_cfg_push_pull(irq_pp), .wake_event_enable_bit(wk_en),
    .wake_cfg_act_high(wk_hi), .wake_cfg_push_pull(wk_pp),
    .wake_detect(wk_det), .chip_reset_active(chip_rst),
    .serial_rom_select_out(rom_sel), .rom_two_wire(two_wire),
    .rom_size_sel(size_sel), .port1_crossover_en(x1),
    .port2_crossover_en(x2), .gpio_pin_out(g_out), .gpio_pin_oe(g_oe),
    .gpio_in_buf_en(g_buf), .gpio_data_in(g_din), .irq_pin_out(irq_o),
    .irq_pin_oe(irq_oe), .wake_event_out(wk_o), .wake_event_oe(wk_oe));

  slp_far_side far (
    .rst_req(rst_req), .strap_drv(strap_drv), .strap_val(strap_val),
    .gpio_o(g_out), .gpio_oe(g_oe), .gpio_ext_low(ext_low),
    .irq_o(irq_o), .irq_oe(irq_oe), .wake_o(wk_o), .wake_oe(wk_oe),
    .sys_rst_b(sys_rst_b), .strap_pins(straps), .gpio_wire(gpio_wire),
    .irq_wire(irq_wire), .wake_wire(wake_wire));

  // ===========================================================================
  // clock, shared compare and closing
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ===========================================================================
  // chip reset through either source, then latch and decode the straps;
  // the strap pins are released afterwards and must not leak through
  task automatic relatch(input logic [4:0] s, input logic use_por);
    int n;
    @(negedge clk);
    strap_val = s;
    strap_drv = 1'b1;
    if (use_por) por_b = 1'b0;
    else rst_req = 1'b1;
    repeat (6) @(negedge clk);
    chk(chip_rst, 8'h01, "chip reset flag");
    chk(rom_sel, 8'h00, "rom select in reset");
    chk({irq_wire, wake_wire}, {~irq_hi, ~wk_hi}, "idle in reset");
    por_b = 1'b1;
    rst_req = 1'b0;
    n = 0;
    while (chip_rst !== 1'b0 && n < 60) begin
      @(negedge clk);
      n++;
    end
    chk(chip_rst, 8'h00, "reset release");
    repeat (2) @(negedge clk);
    strap_drv = 1'b0;
    repeat (4) @(negedge clk);
    chk({two_wire, size_sel, x1, x2},
        {s[0], s[0] ? 1'b0 : s[2], s[1], s[3], s[4]},
        "strap decode");
  endtask

  task automatic t_straps;
    logic [4:0] tbl [5] = '{5'h00, 5'h1F, 5'h0A, 5'h15, 5'h06};
    for (int i = 0; i < 5; i++) begin
      relatch(tbl[i], i[0]);
    end
    $display("done: strap latch");
  endtask

  // ===========================================================================
  // three-wire select follows the request only in kind 0
  task automatic t_rom_sel;
    relatch(5'h18, 1'b0);
    @(negedge clk);
    rom_req = 1'b1;
    repeat (2) @(negedge clk);
    chk(rom_sel, 8'h01, "select kind 0");
    rom_req = 1'b0;
    repeat (2) @(negedge clk);
    chk(rom_sel, 8'h00, "deselect kind 0");
    rom_req = 1'b1;
    relatch(5'h19, 1'b1);
    chk(rom_sel, 8'h00, "select two-wire");
    rom_req = 1'b0;
    $display("done: rom select");
  endtask

  // ===========================================================================
  // loader overrides: frozen clock ignores, back-to-back both apply
  task automatic t_override;
    relatch(5'h18, 1'b0);
    @(negedge clk);
    clk_en = 1'b0;
    ov_stb = 1'b1;
    ov_mask = 5'h1F;
    ov_val = 5'h07;
    @(negedge clk);
    ov_stb = 1'b0;
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    chk({two_wire, size_sel, x1, x2}, 8'h03, "frozen override");
    ov_stb = 1'b1;
    ov_mask = 5'h01;
    ov_val = 5'h01;
    @(negedge clk);
    ov_mask = 5'h18;
    ov_val = 5'h00;
    @(negedge clk);
    ov_stb = 1'b0;
    repeat (2) @(negedge clk);
    chk({two_wire, size_sel, x1, x2}, 8'h10, "override pair");
    ov_stb = 1'b1;
    ov_mask = 5'h07;
    ov_val = 5'h06;
    @(negedge clk);
    ov_stb = 1'b0;
    repeat (2) @(negedge clk);
    chk({two_wire, size_sel, x1, x2}, 8'h0C, "override size");
    $display("done: loader override");
  endtask

  // ===========================================================================
  // every gpio mode code with both data patterns; pins 0 and 1 pulled low
  task automatic t_gpio;
    logic inp;
    for (int m = 0; m < 4; m++) begin
      for (int d = 0; d < 2; d++) begin
        @(negedge clk);
        gpio_mode = {4{m[1:0]}};
        gpio_dat = d[0] ? 4'hA : 4'h5;
        ext_low = 4'h3;
        repeat (5) @(negedge clk);
        inp = (m == 0 || m == 3);
        chk(g_buf, inp ? 8'h0F : 8'h00, "input buffer");
        chk(g_oe, inp ? 4'h0 : (m == 1 ? 4'hF : 4'(~gpio_dat)),
            "gpio oe");
        chk(g_out, m == 1 ? gpio_dat : 4'h0, "gpio out");
        chk(g_din, inp ? 8'h0C : 8'h00, "gpio in");
      end
    end
    $display("done: gpio");
  endtask

  // ===========================================================================
  // interrupt and wake across source, activity, polarity and type
  task automatic t_irq_wake;
    logic act, lvl, wl;
    for (int k = 0; k < 16; k++) begin
      @(negedge clk);
      act = k[2];
      irq_sel = k[1:0];
      irq_src = act ? (4'h1 << k[1:0]) : ~(4'h1 << k[1:0]);
      irq_en = 1'b1;
      irq_hi = k[3];
      irq_pp = k[0];
      wk_en = 1'b1;
      wk_det = act;
      wk_hi = k[1];
      wk_pp = k[3];
      repeat (3) @(negedge clk);
      lvl = act ? irq_hi : ~irq_hi;
      wl = act ? wk_hi : ~wk_hi;
      chk({irq_oe, irq_o}, irq_pp ? {1'b1, lvl} : {~lvl, 1'b0}, "irq pin");
      chk({wk_oe, wk_o}, wk_pp ? {1'b1, wl} : {~wl, 1'b0}, "wake pin");
      chk({irq_wire, wake_wire}, {lvl, wl}, "irq wake wire");
    end
    irq_en = 1'b0;
    irq_src = 4'hF;
    wk_en = 1'b0;
    wk_det = 1'b1;
    repeat (3) @(negedge clk);
    chk({irq_wire, wake_wire}, {~irq_hi, ~wk_hi}, "disabled");
    irq_en = 1'b1;
    wk_en = 1'b1;
    relatch(5'h18, 1'b1);
    $display("done: interrupt and wake");
  endtask

  // ===========================================================================
  // main sequence and watchdog
  initial begin
    {rst_b, clk_en, por_b, rst_req, strap_drv} = 5'h0B;
    {strap_val, ov_stb, ov_mask, ov_val, rom_req} = 17'h18 << 12;
    {gpio_mode, gpio_dat, ext_low, irq_sel, irq_src} = 22'h0;
    {irq_en, irq_hi, irq_pp, wk_en, wk_hi, wk_pp, wk_det} = 7'h0;
    err_total = 0;
    checks = 0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_straps();
    t_rom_sel();
    t_override();
    t_gpio();
    t_irq_wake();
    close_out();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    close_out();
  end
endmodule
`default_nettype wire
